//--- srm_pkg.sv
// Shared constants for the sensor readout mode register bank and its controller
package srm_pkg;

  // Register bank layout, one entry per register
  localparam int NREG = 32;

  localparam int IDX_WINDOW     = 2;
  localparam int IDX_HBIN       = 3;
  localparam int IDX_VBIN       = 4;
  localparam int IDX_BINSEL     = 5;
  localparam int IDX_FRAME      = 6;
  localparam int IDX_LINE       = 7;
  localparam int IDX_SCAN       = 8;
  localparam int IDX_CONV       = 9;
  localparam int IDX_OUTD       = 10;
  localparam int IDX_RATE       = 11;
  localparam int IDX_CLAMP_ST   = 12;
  localparam int IDX_CLAMP_CNT  = 13;
  localparam int IDX_LANES      = 19;
  localparam int IDX_TIME_FIRST = 22;
  localparam int NTIME          = 9;

  localparam logic [15:0] REG_OFS [NREG] = '{
    16'h3008, 16'h300a, 16'h301c, 16'h3020, 16'h3021, 16'h3022, 16'h3024, 16'h3028,
    16'h3030, 16'h3031, 16'h3032, 16'h3033, 16'h30d9, 16'h30da, 16'h3115, 16'h3116,
    16'h3118, 16'h311a, 16'h311e, 16'h4001, 16'h4004, 16'h400c, 16'h4018, 16'h401a,
    16'h401c, 16'h401e, 16'h4020, 16'h4022, 16'h4024, 16'h4026, 16'h4028, 16'h4074};

  localparam int REG_W [NREG] = '{
    10, 10, 4, 1, 1, 2, 20, 16, 2, 2, 1, 4, 5, 2, 8, 8,
    11, 11, 8, 3, 16, 1, 16, 16, 16, 16, 16, 16, 16, 16, 16, 3};

  localparam logic [23:0] REG_RST [NREG] = '{
    24'h00_00ff, 24'h00_00b6, 24'h00_0000, 24'h00_0000,
    24'h00_0000, 24'h00_0000, 24'h00_08ca, 24'h00_0226,
    24'h00_0000, 24'h00_0001, 24'h00_0001, 24'h00_0004,
    24'h00_0006, 24'h00_0002, 24'h00_0000, 24'h00_0028,
    24'h00_00c0, 24'h00_00e0, 24'h00_0028, 24'h00_0003,
    24'h00_1290, 24'h00_0001, 24'h00_00b7, 24'h00_0067,
    24'h00_006f, 24'h00_01df, 24'h00_006f, 24'h00_00cf,
    24'h00_006f, 24'h00_00b7, 24'h00_005f, 24'h00_0000};

  // Field decodes
  localparam int            SCAN_HFLIP   = 0;
  localparam int            SCAN_VFLIP   = 1;
  localparam logic [1:0]    DEPTH_12BIT  = 2'h1;
  localparam logic [1:0]    DEPTH_10BIT  = 2'h0;
  localparam logic [2:0]    LANES_FOUR   = 3'h3;
  localparam logic [2:0]    LANES_TWO    = 3'h1;
  localparam logic [3:0]    WINDOW_ALL   = 4'h0;

  // Lane rate codes per lane bit rate
  localparam logic [3:0]    RATE_594     = 4'h7;
  localparam logic [3:0]    RATE_720     = 4'h9;
  localparam logic [3:0]    RATE_891     = 4'h5;
  localparam logic [3:0]    RATE_1440    = 4'h8;

  // Line lengths for four lanes at 594 Mbps
  localparam logic [15:0]   LINE_20FPS   = 16'h0672;
  localparam logic [15:0]   LINE_25FPS   = 16'h0528;

  // Clamp settings in binning mode
  localparam logic [7:0]    CLAMP_BIN_ST  = 8'h02;
  localparam logic [7:0]    CLAMP_BIN_CNT = 8'h01;
  localparam int            PRESET_LAST   = 9;

  // Controller registers, word addresses on the Avalon slave
  localparam logic [2:0]    AV_ADDR      = 3'h0;
  localparam logic [2:0]    AV_WDATA     = 3'h1;
  localparam logic [2:0]    AV_CTRL      = 3'h2;
  localparam logic [2:0]    AV_STATUS    = 3'h3;
  localparam int            CTRL_WR      = 0;
  localparam int            CTRL_RD      = 1;
  localparam int            CTRL_PRESET  = 2;
  localparam int            CTRL_FPS25   = 3;
  localparam int            CTRL_BIN     = 4;
  localparam int            ST_BUSY      = 0;
  localparam int            ST_DONE      = 1;
  localparam int            ST_RDATA     = 8;

  typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_GAP} srm_host_state_t;

  function automatic logic [23:0] srm_mask(input int w);
    return ~(24'hff_ffff << w);
  endfunction

endpackage

//--- srm_if.sv
// Byte-wide register link between controller and sensor register bank
`timescale 1ns/100ps
interface srm_if;
  logic        req;    // Access request, held until ack
  logic        we;     // 1 write, 0 read
  logic [15:0] addr;   // Byte address
  logic [7:0]  wdata;  // Write byte
  logic        ack;    // One-cycle answer
  logic [7:0]  rdata;  // Read byte, valid with ack

  modport dev  (input req, we, addr, wdata, output ack, rdata);
  modport host (output req, we, addr, wdata, input ack, rdata);
endinterface

//--- srm_line_timer.sv
// Line and frame timing generator driven by the programmed lengths
`timescale 1ns/100ps
module srm_line_timer (
  input  wire logic        mclk,        // Clock
  input  wire logic        arst_n,      // Async reset, active low
  input  wire logic [15:0] line_len,    // Clocks per line
  input  wire logic [19:0] frame_len,   // Lines per frame
  output logic             line_start,  // Pulse at each line
  output logic             frame_start, // Pulse at each frame
  output logic [19:0]      line_index   // Current line
);
  logic [15:0] clk_cnt;

  // Line length counts clocks, frame length counts lines
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clk_cnt <= 16'h0000;
    end else if (clk_cnt + 16'h0001 >= line_len) begin
      clk_cnt <= 16'h0000;
    end else begin
      clk_cnt <= clk_cnt + 16'h0001;
    end
  end

  // Frame period is frame lines times one line period
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      line_index  <= 20'h0_0000;
      line_start  <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      line_start  <= (clk_cnt == 16'h0000);
      frame_start <= (clk_cnt == 16'h0000) && (line_index == 20'h0_0000);
      if (clk_cnt + 16'h0001 >= line_len) begin
        line_index <= (line_index + 20'h0_0001 >= frame_len) ? 20'h0_0000
                                                             : line_index + 20'h0_0001;
      end
    end
  end
endmodule // srm_line_timer

//--- srm_device.sv
// Sensor readout mode register bank with decoded mode outputs and frame timing
//
// Behaviour
// - Direction register bits flip horizontal, vertical.
// - Bit-depth fields: zero 10-bit, one 12-bit.
// - Lane count 3 selects four, 1 two.
// - Inverted binning pairs shift one same-colour pixel.
// - Horizontal, vertical binning enables reset to zero.
// - Binning: host sets clamp start 02h, count 1h.
// - Binning: conversion 10-bit, output stays 12-bit.
// - Window field zero selects all-pixel readout.
// - Frame length spans three bytes, resets 8CAh.
// - Host programs line length for chosen rate.
// - Host sets lane rate code per bitrate.
// - Link timing from byte-pair registers, post 00B7h.
// - Frame rate is one over lines times line.
// - Frame counts lines, line counts input clocks.
`timescale 1ns/100ps
module srm_device (
  input  wire logic        mclk,             // Clock, 50 MHz
  input  wire logic        arst_n,           // Async reset, active low
  srm_if.dev               link,             // Register link from controller
  output logic             horiz_flip,       // Horizontal readout inverted
  output logic             vert_flip,        // Vertical readout inverted
  output logic             horiz_bin_enable, // Horizontal 2-pixel binning
  output logic             vert_bin_enable,  // Vertical 2-line binning
  output logic [1:0]       binning_select,   // Binning mode field
  output logic             horiz_pair_shift, // Binned pair is second and third
  output logic             vert_pair_shift,  // Binned line pair is second and third
  output logic             conv_12bit,       // Conversion depth is 12 bit
  output logic             out_12bit,        // Output depth is 12 bit
  output logic             lanes_four,       // Four-lane output selected
  output logic             lanes_two,        // Two-lane output selected
  output logic             all_pixel,        // Uncropped all-pixel readout
  output logic [3:0]       window_select,    // Window mode field
  output logic [3:0]       lane_rate_code,   // Lane rate system code
  output logic [4:0]       clamp_vert_start, // Clamp vertical start
  output logic [1:0]       clamp_vert_count, // Clamp line count
  output logic [15:0]      link_time [srm_pkg::NTIME], // Serial link timing values
  output logic [19:0]      frame_length_lines, // Lines per frame
  output logic [15:0]      line_length_clocks, // Clocks per line
  output logic             line_start,       // Pulse at each line
  output logic             frame_start,      // Pulse at each frame
  output logic [19:0]      line_index        // Current line in frame
);

  logic [23:0] regs [srm_pkg::NREG];
  logic        take;
  logic [7:0]  next_rdata;
  logic        ack_q;
  logic        line_pulse;
  logic        frame_pulse;
  logic [19:0] line_idx;

  // A request is taken once; ack drops before the host may issue the next
  assign take = link.req && !ack_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  assign link.ack = ack_q;

  // One storage word per register, written byte by byte
  for (genvar i = 0; i < srm_pkg::NREG; i++) begin : g_reg
    localparam int          NBYTES = (srm_pkg::REG_W[i] + 7) / 8;
    localparam logic [23:0] MASK   = srm_pkg::srm_mask(srm_pkg::REG_W[i]);
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        regs[i] <= srm_pkg::REG_RST[i];
      end else if (take && link.we) begin
        for (int k = 0; k < NBYTES; k++) begin
          // Low byte at the lowest address, bits beyond the width dropped
          if (link.addr == 16'(srm_pkg::REG_OFS[i] + 16'(k))) begin
            regs[i][8*k +: 8] <= link.wdata & MASK[8*k +: 8];
          end
        end
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < srm_pkg::NREG; i++) begin
      for (int k = 0; k < (srm_pkg::REG_W[i] + 7) / 8; k++) begin
        if (link.addr == 16'(srm_pkg::REG_OFS[i] + 16'(k))) begin
          next_rdata = regs[i][8*k +: 8];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.rdata <= 8'h00;
    end else if (take && !link.we) begin
      link.rdata <= next_rdata;
    end
  end

  // Plain field outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      horiz_flip         <= 1'b0;
      vert_flip          <= 1'b0;
      horiz_bin_enable   <= 1'b0;
      vert_bin_enable    <= 1'b0;
      binning_select     <= 2'h0;
      window_select      <= 4'h0;
      lane_rate_code     <= 4'h0;
      clamp_vert_start   <= 5'h00;
      clamp_vert_count   <= 2'h0;
      frame_length_lines <= 20'h0_0000;
      line_length_clocks <= 16'h0000;
    end else begin
      horiz_flip         <= regs[srm_pkg::IDX_SCAN][srm_pkg::SCAN_HFLIP];
      vert_flip          <= regs[srm_pkg::IDX_SCAN][srm_pkg::SCAN_VFLIP];
      horiz_bin_enable   <= regs[srm_pkg::IDX_HBIN][0];
      vert_bin_enable    <= regs[srm_pkg::IDX_VBIN][0];
      binning_select     <= regs[srm_pkg::IDX_BINSEL][1:0];
      window_select      <= regs[srm_pkg::IDX_WINDOW][3:0];
      lane_rate_code     <= regs[srm_pkg::IDX_RATE][3:0];
      clamp_vert_start   <= regs[srm_pkg::IDX_CLAMP_ST][4:0];
      clamp_vert_count   <= regs[srm_pkg::IDX_CLAMP_CNT][1:0];
      frame_length_lines <= regs[srm_pkg::IDX_FRAME][19:0];
      line_length_clocks <= regs[srm_pkg::IDX_LINE][15:0];
    end
  end

  // Decoded modes; a conversion depth other than 1 leaves conv_12bit low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_12bit       <= 1'b0;
      out_12bit        <= 1'b0;
      lanes_four       <= 1'b0;
      lanes_two        <= 1'b0;
      all_pixel        <= 1'b0;
      horiz_pair_shift <= 1'b0;
      vert_pair_shift  <= 1'b0;
    end else begin
      conv_12bit <= regs[srm_pkg::IDX_CONV][1:0] == srm_pkg::DEPTH_12BIT;
      out_12bit  <= regs[srm_pkg::IDX_OUTD][0];
      lanes_four <= regs[srm_pkg::IDX_LANES][2:0] == srm_pkg::LANES_FOUR;
      lanes_two  <= regs[srm_pkg::IDX_LANES][2:0] == srm_pkg::LANES_TWO;
      all_pixel  <= regs[srm_pkg::IDX_WINDOW][3:0] == srm_pkg::WINDOW_ALL;
      // Inverted scan merges the second and third same-colour pixels
      horiz_pair_shift <= regs[srm_pkg::IDX_HBIN][0]
                          && regs[srm_pkg::IDX_SCAN][srm_pkg::SCAN_HFLIP];
      vert_pair_shift  <= regs[srm_pkg::IDX_VBIN][0]
                          && regs[srm_pkg::IDX_SCAN][srm_pkg::SCAN_VFLIP];
    end
  end

  // Serial link timing values, each a byte pair
  for (genvar t = 0; t < srm_pkg::NTIME; t++) begin : g_time
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        link_time[t] <= 16'h0000;
      end else begin
        link_time[t] <= regs[srm_pkg::IDX_TIME_FIRST + t][15:0];
      end
    end
  end

  // Timing uses live register values so a new length acts at once on the line or frame in progress
  srm_line_timer u_timer (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .line_len    (regs[srm_pkg::IDX_LINE][15:0]),
    .frame_len   (regs[srm_pkg::IDX_FRAME][19:0]),
    .line_start  (line_pulse),
    .frame_start (frame_pulse),
    .line_index  (line_idx)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      line_start  <= 1'b0;
      frame_start <= 1'b0;
      line_index  <= 20'h0_0000;
    end else begin
      line_start  <= line_pulse;
      frame_start <= frame_pulse;
      line_index  <= line_idx;
    end
  end

endmodule // srm_device

//--- srm_host.sv
// Controller end: Avalon-MM command registers and register link master
`timescale 1ns/100ps
module srm_host (
  input  wire logic        mclk,              // Clock, 50 MHz
  input  wire logic        arst_n,            // Async reset, active low
  srm_if.host              link,              // Register link to sensor bank
  input  wire logic [2:0]  avs_address,       // Word address
  input  wire logic        avs_read,          // Read strobe
  input  wire logic        avs_write,         // Write strobe
  input  wire logic [31:0] avs_writedata,     // Write data
  output logic [31:0]      avs_readdata,      // Read data
  output logic             avs_waitrequest    // Stall, high until answer
);

  srm_pkg::srm_host_state_t state;
  logic [15:0] byte_addr;     // Link address for the next access
  logic [7:0]  byte_data;     // Link write byte
  logic [7:0]  rdata_q;       // Byte from the last link read
  logic        busy;          // Command in progress
  logic        done;          // Last command finished
  logic        preset_run;    // Preset sequence active
  logic        fps25;         // Preset for 25 frame/s
  logic        bin;           // Preset for binning
  logic [3:0]  step;          // Next preset entry
  logic        av_take;       // Avalon request completes at this edge
  logic        cmd_go;        // Command write completes at this edge
  logic [15:0] p_addr;        // Preset entry address
  logic [7:0]  p_data;        // Preset entry byte
  logic [31:0] next_readdata; // Read word for the current address

  assign av_take = (avs_read || avs_write) && !avs_waitrequest;
  assign cmd_go  = av_take && avs_write && avs_address == srm_pkg::AV_CTRL;

  // One wait state: the answer stands at the second edge of every request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      srm_pkg::AV_ADDR: next_readdata[15:0] = byte_addr;
      srm_pkg::AV_WDATA: next_readdata[7:0] = byte_data;
      srm_pkg::AV_STATUS: begin
        next_readdata[srm_pkg::ST_BUSY] = busy;
        next_readdata[srm_pkg::ST_DONE] = done;
        next_readdata[srm_pkg::ST_RDATA +: 8] = rdata_q;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      byte_addr <= 16'h0000;
      byte_data <= 8'h00;
    end else if (av_take && avs_write) begin
      if (avs_address == srm_pkg::AV_ADDR) byte_addr <= avs_writedata[15:0];
      if (avs_address == srm_pkg::AV_WDATA) byte_data <= avs_writedata[7:0];
    end
  end

  // Preset for four lanes at 594 Mbps; clamp returns to reset values outside binning
  always_comb begin
    p_addr = 16'h0000;
    p_data = 8'h00;
    case (step)
      4'h0: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_LINE];
        p_data = fps25 ? srm_pkg::LINE_25FPS[7:0] : srm_pkg::LINE_20FPS[7:0];
      end
      4'h1: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_LINE] + 16'h0001;
        p_data = fps25 ? srm_pkg::LINE_25FPS[15:8] : srm_pkg::LINE_20FPS[15:8];
      end
      4'h2: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_RATE];
        p_data = {4'h0, srm_pkg::RATE_594};
      end
      4'h3: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_LANES];
        p_data = {5'h00, srm_pkg::LANES_FOUR};
      end
      4'h4: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_CONV];
        p_data = {6'h00, bin ? srm_pkg::DEPTH_10BIT : srm_pkg::DEPTH_12BIT};
      end
      4'h5: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_OUTD];
        p_data = {6'h00, srm_pkg::DEPTH_12BIT};
      end
      4'h6: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_HBIN];
        p_data = {7'h00, bin};
      end
      4'h7: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_VBIN];
        p_data = {7'h00, bin};
      end
      4'h8: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_CLAMP_ST];
        p_data = bin ? srm_pkg::CLAMP_BIN_ST : srm_pkg::REG_RST[srm_pkg::IDX_CLAMP_ST][7:0];
      end
      4'h9: begin
        p_addr = srm_pkg::REG_OFS[srm_pkg::IDX_CLAMP_CNT];
        p_data = bin ? srm_pkg::CLAMP_BIN_CNT : srm_pkg::REG_RST[srm_pkg::IDX_CLAMP_CNT][7:0];
      end
      default: p_data = 8'h00;
    endcase
  end

  // Commands arriving while busy are dropped; software polls busy first
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= srm_pkg::HS_IDLE;
      busy       <= 1'b0;
      done       <= 1'b0;
      preset_run <= 1'b0;
      fps25      <= 1'b0;
      bin        <= 1'b0;
      step       <= 4'h0;
      rdata_q    <= 8'h00;
      link.req   <= 1'b0;
      link.we    <= 1'b0;
      link.addr  <= 16'h0000;
      link.wdata <= 8'h00;
    end else begin
      case (state)
        srm_pkg::HS_IDLE: begin
          if (cmd_go && avs_writedata[srm_pkg::CTRL_PRESET]) begin
            busy       <= 1'b1;
            done       <= 1'b0;
            preset_run <= 1'b1;
            fps25      <= avs_writedata[srm_pkg::CTRL_FPS25];
            bin        <= avs_writedata[srm_pkg::CTRL_BIN];
            step       <= 4'h0;
            state      <= srm_pkg::HS_GAP;
          end else if (cmd_go && (avs_writedata[srm_pkg::CTRL_WR]
                                  || avs_writedata[srm_pkg::CTRL_RD])) begin
            busy       <= 1'b1;
            done       <= 1'b0;
            link.req   <= 1'b1;
            link.we    <= avs_writedata[srm_pkg::CTRL_WR];
            link.addr  <= byte_addr;
            link.wdata <= byte_data;
            state      <= srm_pkg::HS_REQ;
          end
        end
        srm_pkg::HS_REQ: begin
          // Request held with its address and data until the answer
          if (link.ack) begin
            link.req <= 1'b0;
            if (!link.we) rdata_q <= link.rdata;
            state <= srm_pkg::HS_GAP;
          end
        end
        srm_pkg::HS_GAP: begin
          // Idle cycle between accesses so the bank sees the request drop
          if (preset_run && step <= 4'(srm_pkg::PRESET_LAST)) begin
            link.req   <= 1'b1;
            link.we    <= 1'b1;
            link.addr  <= p_addr;
            link.wdata <= p_data;
            step       <= step + 4'h1;
            state      <= srm_pkg::HS_REQ;
          end else begin
            busy       <= 1'b0;
            done       <= 1'b1;
            preset_run <= 1'b0;
            state      <= srm_pkg::HS_IDLE;
          end
        end
        default: state <= srm_pkg::HS_IDLE;
      endcase
    end
  end
endmodule // srm_host

//--- srm_link_checker.sv
// Handshake and readback checks on the controller-to-bank register link
`timescale 1ns/100ps
module srm_link_checker (
  input wire logic        mclk,   // Clock
  input wire logic        arst_n, // Async reset
  input wire logic        req,    // Request
  input wire logic        we,     // Write
  input wire logic [15:0] addr,   // Byte address
  input wire logic [7:0]  wdata,  // Write byte
  input wire logic        ack,    // Answer
  input wire logic [7:0]  rdata   // Read byte
);
  logic [3:0] rate;
  logic [7:0] post;
  logic [4:0] stall;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Shadows let a read be judged without seeing the bank's storage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rate <= 4'h4;
      post <= 8'hb7;
    end else if (ack && we) begin
      rate <= (addr == 16'h3033) ? wdata[3:0] : rate;
      post <= (addr == 16'h4018) ? wdata : post;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stall <= 5'h00;
    end else begin
      stall <= (req && !ack) ? stall + 5'h01 : 5'h00;
    end
  end
  a_req_held: assert property (
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("link request moved before answer");
  a_ack_has_req: assert property (ack |-> req)
    else $error("answer without request");
  a_ack_single: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  a_req_ends: assert property (ack |=> !req)
    else $error("request kept after answer");
  a_ack_bounded: assert property ($rose(req) |-> ##[0:16] ack)
    else $error("answer too late");
  a_stall_short: assert property (stall < 5'h11)
    else $error("request stalled too long");
  a_rate_back: assert property (
    ack && !we && addr == 16'h3033 |-> rdata[3:0] == rate)
    else $error("lane rate code read back wrong");
  a_post_back: assert property (
    ack && !we && addr == 16'h4018 |-> rdata == post)
    else $error("clock post low byte read back wrong");
endmodule // srm_link_checker

//--- test_sensor_readout_mode_config.sv
// Bench joining controller and register bank through the link
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module test_sensor_readout_mode_config;
  logic        mclk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, s;
  logic [7:0]  q;
  logic        horiz_flip, vert_flip, horiz_bin_enable, vert_bin_enable;
  logic        horiz_pair_shift, vert_pair_shift, conv_12bit, out_12bit;
  logic        lanes_four, lanes_two, all_pixel, line_start, frame_start;
  logic [1:0]  binning_select, clamp_vert_count;
  logic [3:0]  window_select, lane_rate_code;
  logic [4:0]  clamp_vert_start;
  logic [15:0] link_time [srm_pkg::NTIME];
  logic [15:0] line_length_clocks;
  logic [19:0] frame_length_lines, line_index;
  int          n_mismatch = 0;
  int          compares = 0;
  int          n, k;
  srm_if lnk();
  srm_host u_srm_host (.mclk, .arst_n, .link(lnk), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  srm_device u_srm_device (.mclk, .arst_n, .link(lnk), .horiz_flip, .vert_flip,
    .horiz_bin_enable, .vert_bin_enable, .binning_select, .horiz_pair_shift,
    .vert_pair_shift, .conv_12bit, .out_12bit, .lanes_four, .lanes_two, .all_pixel,
    .window_select, .lane_rate_code, .clamp_vert_start, .clamp_vert_count, .link_time,
    .frame_length_lines, .line_length_clocks, .line_start, .frame_start, .line_index);
  srm_link_checker u_srm_link_checker (.mclk, .arst_n, .req(lnk.req), .we(lnk.we),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));
  // Held until waitrequest is seen low at an edge; the bench timer cuts a hang
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    s = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cmd(input logic [31:0] c);
    av(1'b1, srm_pkg::AV_CTRL, c);
    s = 32'h0000_0001;
    for (k = 0; k < 40 && s[srm_pkg::ST_BUSY] !== 1'b0; k++) begin
      av(1'b0, srm_pkg::AV_STATUS, 32'h0000_0000);
    end
    `CHK("busy", 1'b0, s[srm_pkg::ST_BUSY])
  endtask
  task automatic lk(input logic wr, input logic [15:0] a, input logic [7:0] d);
    av(1'b1, srm_pkg::AV_ADDR, {16'h0000, a});
    av(1'b1, srm_pkg::AV_WDATA, {24'h00_0000, d});
    cmd(32'h0000_0001 << (wr ? srm_pkg::CTRL_WR : srm_pkg::CTRL_RD));
    q = s[srm_pkg::ST_RDATA +: 8];
  endtask
  task automatic t_reset;
    `CHK("depth", 2'h3, {conv_12bit, out_12bit})
    `CHK("lanes", 2'h2, {lanes_four, lanes_two})
    `CHK("window", 5'h10, {all_pixel, window_select})
    `CHK("bin", 2'h0, {horiz_bin_enable, vert_bin_enable})
    `CHK("frame", 20'h0_08ca, frame_length_lines)
    `CHK("line", 16'h0226, line_length_clocks)
    `CHK("post", 16'h00b7, link_time[0])
    $display("reset test done");
  endtask
  task automatic t_flip;
    lk(1'b1, 16'h3020, 8'h01);
    lk(1'b1, 16'h3021, 8'h01);
    `CHK("bin", 2'h3, {horiz_bin_enable, vert_bin_enable})
    // Upper bits set on purpose; only the two flip bits may land
    for (int i = 0; i < 4; i++) begin
      lk(1'b1, 16'h3030, 8'hfc | 8'(i));
      lk(1'b0, 16'h3030, 8'h00);
      `CHK("flip", 2'(i), {vert_flip, horiz_flip})
      `CHK("shift", 2'(i), {vert_pair_shift, horiz_pair_shift})
      `CHK("back", 2'(i), q[1:0])
    end
    $display("flip test done");
  endtask
  task automatic t_fields;
    lk(1'b1, 16'h3031, 8'h00);
    lk(1'b1, 16'h3032, 8'h00);
    lk(1'b1, 16'h4001, 8'h01);
    lk(1'b1, 16'h301c, 8'h04);
    lk(1'b1, 16'h3022, 8'hff);
    `CHK("binsel", 2'h3, binning_select)
    `CHK("depth", 2'h0, {conv_12bit, out_12bit})
    `CHK("lanes", 2'h1, {lanes_four, lanes_two})
    `CHK("window", 5'h04, {all_pixel, window_select})
    for (int i = 0; i < srm_pkg::NTIME; i++) begin
      lk(1'b1, 16'h4018 + 16'(2 * i), 8'h10 + 8'(i));
      lk(1'b1, 16'h4019 + 16'(2 * i), 8'h01);
      `CHK("time", 16'h0110 + 16'(i), link_time[i])
    end
    lk(1'b0, 16'h4018, 8'h00);
    $display("field test done");
  endtask
  task automatic t_preset;
    cmd(32'h0000_001c); // Preset with 25 frame/s and binning
    `CHK("clamp", 7'h09, {clamp_vert_start, clamp_vert_count})
    `CHK("depth", 2'h1, {conv_12bit, out_12bit})
    `CHK("line", 16'h0528, line_length_clocks)
    `CHK("rate", 4'h7, lane_rate_code)
    cmd(32'h0000_0004);
    `CHK("line", 16'h0672, line_length_clocks)
    lk(1'b1, 16'h3027, 8'hff);
    lk(1'b0, 16'h3033, 8'h00);
    `CHK("rate", 4'h7, q[3:0])
    `CHK("line", 16'h0672, line_length_clocks)
    av(1'b0, 3'h7, 32'h0000_0000);
    $display("preset test done");
  endtask
  task automatic t_frame;
    lk(1'b1, 16'h3024, 8'h34);
    lk(1'b1, 16'h3025, 8'h12);
    lk(1'b1, 16'h3026, 8'hf5);
    `CHK("frame", 20'h5_1234, frame_length_lines)
    lk(1'b1, 16'h3024, 8'h04);
    lk(1'b1, 16'h3025, 8'h00);
    lk(1'b1, 16'h3026, 8'h00);
    lk(1'b1, 16'h3028, 8'h14);
    lk(1'b1, 16'h3029, 8'h00);
    for (n = 0; n < 3000 && frame_start !== 1'b1; n++) @(posedge mclk);
    n = 0;
    k = 0;
    do begin
      @(posedge mclk);
      n++;
      k += (line_start === 1'b1);
    end while (frame_start !== 1'b1 && n < 200);
    `CHK("period", 80, n)
    `CHK("lines", 4, k)
    `CHK("index", 20'h0_0000, line_index)
    $display("frame test done");
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0000_0000;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset;
    t_flip;
    t_fields;
    t_preset;
    t_frame;
    give_verdict;
  end
endmodule // test_sensor_readout_mode_config
